// ===== logic/fcp_map.vh
// Purpose: Register offsets, field positions, reset values and timing counts of the pulse unit.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef FCP_MAP_VH
`define FCP_MAP_VH

// ==========================================================================
// Register map
// ==========================================================================
// Channel n start count at 0x00 + 0x10*n, threshold at +0x4, live count at +0x8.
`define FCP_CH_STRIDE       12'h010
`define FCP_OFS_START       4'h0
`define FCP_OFS_THRESH      4'h4
`define FCP_OFS_LIVE        4'h8
`define FCP_ADDR_SETUP      12'h040
`define FCP_ADDR_DIVIDER    12'h044

// ==========================================================================
// Field layout of the shared setup register
// ==========================================================================
`define FCP_SETUP_W         12
`define FCP_EN_LSB          0
`define FCP_CLKSEL_LSB      4
`define FCP_INV_LSB         8
`define FCP_SETUP_RESET     12'h000

// ==========================================================================
// Widths, reset values and timing
// ==========================================================================
`define FCP_CNT_W           10
`define FCP_CNT_MAX         10'h3FF
`define FCP_START_RESET     10'h000
`define FCP_THRESH_RESET    10'h000
`define FCP_DIV_W           16
`define FCP_DIV_RESET       16'h0063

`endif

// ===== logic/fcp_tick_div.v
// Purpose: Makes the slow one-cycle tick that channels may choose as their count clock.
// Assumes: One clock, synchronous active-high reset.
// Notes:   A tick every (reload + 1) cycles of core_clk.
`timescale 1ns/10ps
`include "fcp_map.vh"

module fcp_tick_div (
    input  wire                   core_clk,
    input  wire                   reset,
    input  wire [`FCP_DIV_W-1:0]  reload,
    output reg                    tick
);

    reg [`FCP_DIV_W-1:0] count_reg;

    // ======================================================================
    // Down counter
    // ======================================================================
    // The counter restarts from the reload value so a new divider takes effect
    // after the current period ends, which keeps ticks glitch-free.
    always @(posedge core_clk) begin
        if (reset) begin
            count_reg <= 16'h0000;
            tick      <= 1'b0;
        end else if (count_reg == 16'h0000) begin
            count_reg <= reload;
            tick      <= 1'b1;
        end else begin
            count_reg <= count_reg - 16'h0001;
            tick      <= 1'b0;
        end
    end

endmodule

// ===== logic/fcp_channel.v
// Purpose: One pulse-width channel: counter, reload and output toggle.
// Assumes: Enable, tick and setup values come from the register block.
// Notes:   Output level is held at the invert bit while the channel is stopped.
`timescale 1ns/10ps
`include "fcp_map.vh"

module fcp_channel (
    input  wire                   core_clk,
    input  wire                   reset,
    input  wire                   enable,
    input  wire                   step,
    input  wire                   invert,
    input  wire [`FCP_CNT_W-1:0]  start_count,
    input  wire [`FCP_CNT_W-1:0]  threshold,
    output reg  [`FCP_CNT_W-1:0]  live_count,
    output reg                    pulse_out
);

    reg level_reg;

    // ======================================================================
    // Counter and toggle
    // ======================================================================
    // A stopped channel parks its counter at the start count, so the first
    // period after enable is a full one.
    always @(posedge core_clk) begin
        if (reset) begin
            live_count <= `FCP_START_RESET;
            level_reg  <= 1'b0;
        end else if (!enable) begin
            live_count <= start_count;
            level_reg  <= 1'b0;
        end else if (step) begin
            if (live_count == `FCP_CNT_MAX) begin
                live_count <= start_count;
            end else begin
                live_count <= live_count + 10'h001;
            end
            if (live_count == threshold) begin
                level_reg <= ~level_reg;
            end else if (live_count == `FCP_CNT_MAX) begin
                level_reg <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Output phase
    // ======================================================================
    // Inversion applies even when stopped so the idle level follows the phase.
    always @(posedge core_clk) begin
        if (reset) begin
            pulse_out <= 1'b0;
        end else begin
            pulse_out <= level_reg ^ invert;
        end
    end

endmodule

// ===== logic/fcp_pwm_unit.v
// Purpose: Four-channel pulse-width unit with an APB register block and LED port bits.
// Assumes: APB master per the bus protocol; single 100 MHz clock; sync reset.
// Notes:   Slave answers with pready in the access cycle, no wait states.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/10ps
`include "fcp_map.vh"

module fcp_pwm_unit (
    input  wire        core_clk,
    input  wire        reset,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    input  wire [3:0]  pad_select,
    output wire        led_port_bit_a,
    output wire        led_port_bit_b,
    output wire        led_port_bit_c,
    output wire        led_port_bit_d,
    output wire [3:0]  led_port_oe
);

    // ======================================================================
    // Register storage
    // ======================================================================
    reg  [`FCP_SETUP_W-1:0] setup_reg;
    reg  [`FCP_DIV_W-1:0]   divider_reg;
    reg  [`FCP_CNT_W-1:0]   start_reg  [0:3];
    reg  [`FCP_CNT_W-1:0]   thresh_reg [0:3];
    wire [`FCP_CNT_W-1:0]   live_count [0:3];
    wire [3:0]              pulse_channels_zero_to_three;
    wire                    slow_tick;
    wire                    wr_en;
    integer                 i;

    // Returns a hit flag when the address is a channel register at the given offset.
    function chan_hit;
        input [11:0] addr;
        input [3:0]  ofs;
        begin
            chan_hit = (addr[11:6] == 6'h00) && (addr[3:0] == ofs);
        end
    endfunction

    // Returns one if the address maps to any register of this block.
    function addr_mapped;
        input [11:0] addr;
        begin
            addr_mapped = chan_hit(addr, `FCP_OFS_START) ||
                          chan_hit(addr, `FCP_OFS_THRESH) ||
                          chan_hit(addr, `FCP_OFS_LIVE) ||
                          (addr == `FCP_ADDR_SETUP) ||
                          (addr == `FCP_ADDR_DIVIDER);
        end
    endfunction

    // ======================================================================
    // APB handshake
    // ======================================================================
    // Zero wait states: every access completes in its first access cycle.
    // Unmapped addresses answer with pslverr and have no effect.
    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~addr_mapped(paddr);
    assign wr_en   = psel & penable & pwrite & addr_mapped(paddr);

    // ======================================================================
    // Shared setup and divider writes
    // ======================================================================
    // All enable, clock-select and invert groups clear at reset.
    always @(posedge core_clk) begin
        if (reset) begin
            setup_reg   <= `FCP_SETUP_RESET;
            divider_reg <= `FCP_DIV_RESET;
        end else if (wr_en) begin
            if (paddr == `FCP_ADDR_SETUP) begin
                setup_reg <= pwdata[`FCP_SETUP_W-1:0];
            end
            if (paddr == `FCP_ADDR_DIVIDER) begin
                divider_reg <= pwdata[`FCP_DIV_W-1:0];
            end
        end
    end

    // ======================================================================
    // Per-channel registers and channel instances
    // ======================================================================
    // Start count and threshold are plain read/write storage, kept in one
    // process so that each array has a single driver.
    always @(posedge core_clk) begin
        for (i = 0; i < 4; i = i + 1) begin
            if (reset) begin
                start_reg[i]  <= `FCP_START_RESET;
                thresh_reg[i] <= `FCP_THRESH_RESET;
            end else if (wr_en && (paddr[5:4] == i[1:0])) begin
                if (chan_hit(paddr, `FCP_OFS_START)) begin
                    start_reg[i] <= pwdata[`FCP_CNT_W-1:0];
                end
                if (chan_hit(paddr, `FCP_OFS_THRESH)) begin
                    thresh_reg[i] <= pwdata[`FCP_CNT_W-1:0];
                end
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1) begin : g_chan
            // Clock select 0 counts every core cycle, 1 counts divider ticks.
            fcp_channel u_channel (
                .core_clk    (core_clk),
                .reset       (reset),
                .enable      (setup_reg[`FCP_EN_LSB + ch]),
                .step        (setup_reg[`FCP_CLKSEL_LSB + ch] ? slow_tick
                                                               : 1'b1),
                .invert      (setup_reg[`FCP_INV_LSB + ch]),
                .start_count (start_reg[ch]),
                .threshold   (thresh_reg[ch]),
                .live_count  (live_count[ch]),
                .pulse_out   (pulse_channels_zero_to_three[ch])
            );
        end
    endgenerate

    // ======================================================================
    // Slow clock source
    // ======================================================================
    fcp_tick_div u_div (
        .core_clk (core_clk),
        .reset    (reset),
        .reload   (divider_reg),
        .tick     (slow_tick)
    );

    // ======================================================================
    // Read data
    // ======================================================================
    // Read data is registered at the setup-phase edge; reading the live count has
    // no side effect on the channel. Reserved bits read as zero.
    always @(posedge core_clk) begin
        if (reset) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h00000000;
            if (chan_hit(paddr, `FCP_OFS_START)) begin
                prdata <= {22'h000000, start_reg[paddr[5:4]]};
            end else if (chan_hit(paddr, `FCP_OFS_THRESH)) begin
                prdata <= {22'h000000, thresh_reg[paddr[5:4]]};
            end else if (chan_hit(paddr, `FCP_OFS_LIVE)) begin
                prdata <= {22'h000000, live_count[paddr[5:4]]};
            end else if (paddr == `FCP_ADDR_SETUP) begin
                prdata <= {20'h00000, setup_reg};
            end else if (paddr == `FCP_ADDR_DIVIDER) begin
                prdata <= {16'h0000, divider_reg};
            end
        end
    end

    // ======================================================================
    // Port bits
    // ======================================================================
    // The pad mux outside picks one bonded function per pad; pad_select says
    // this unit owns the pad, and only then is the driver enabled.
    assign led_port_bit_a = pulse_channels_zero_to_three[0];
    assign led_port_bit_b = pulse_channels_zero_to_three[1];
    assign led_port_bit_c = pulse_channels_zero_to_three[2];
    assign led_port_bit_d = pulse_channels_zero_to_three[3];
    assign led_port_oe    = pad_select;

endmodule

// ===== verification/fcp_pwm_unit_sva.sv
// Purpose: Port checker for the four-channel pulse unit.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to the top module at the foot of this file.
`timescale 1ns/10ps
// ==========
// Checker
module fcp_pwm_unit_sva (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic [3:0]  pad_select,
    input wire logic        led_port_bit_a,
    input wire logic        led_port_bit_b,
    input wire logic        led_port_bit_c,
    input wire logic        led_port_bit_d,
    input wire logic [3:0]  led_port_oe
);
    logic [11:0] shadow_reg;
    logic [1:0]  quiet_reg;
    logic [3:0]  leds;
    logic        mapped;
    // Decode of the mapped words; the fourth word of each channel is a hole.
    assign mapped = (paddr[1:0] == 2'h0) && ((paddr < 12'h040 && paddr[3:2] != 2'h3)
                    || paddr == 12'h040 || paddr == 12'h044);
    assign leds = {led_port_bit_d, led_port_bit_c, led_port_bit_b, led_port_bit_a};
    // Shadow of the setup word; the quiet count lets the output pipeline settle.
    always @(posedge core_clk) begin
        if (reset) begin
            shadow_reg <= 12'h000;
            quiet_reg  <= 2'h0;
        end else if (psel && penable && pwrite && paddr == 12'h040) begin
            shadow_reg <= pwdata[11:0];
            quiet_reg  <= 2'h0;
        end else if (quiet_reg != 2'h3) begin
            quiet_reg <= quiet_reg + 2'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_ready; pready == (psel && penable); endproperty
    a_ready: assert property (p_ready) else $error("pready not tied to access phase.");
    property p_err; psel && penable |-> pslverr == !mapped; endproperty
    a_err: assert property (p_err) else $error("pslverr wrong for address.");
    property p_bad_rd; psel && penable && !pwrite && !mapped |-> prdata == 32'h0; endproperty
    a_bad_rd: assert property (p_bad_rd) else $error("Unmapped read not zero.");
    property p_upper; psel && penable && !pwrite |-> prdata[31:12] == 20'h0; endproperty
    a_upper: assert property (p_upper) else $error("Upper read bits not zero.");
    property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("prdata moved outside a read.");
    property p_oe; led_port_oe == pad_select; endproperty
    a_oe: assert property (p_oe) else $error("Pad enable not following select.");
    property p_setup_rd;
        psel && penable && !pwrite && paddr == 12'h040 |-> prdata == {20'h0, shadow_reg};
    endproperty
    a_setup_rd: assert property (p_setup_rd) else $error("Setup word readback wrong.");
    property p_stopped; quiet_reg == 2'h3 |-> ((leds ^ shadow_reg[11:8]) & ~shadow_reg[3:0]) == 4'h0;
    endproperty
    a_stopped: assert property (p_stopped) else $error("Stopped channel level wrong.");
    property p_reset; disable iff (1'b0) reset [*3] |-> leds == 4'h0 && prdata == 32'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("Outputs not cleared by reset.");
endmodule

bind fcp_pwm_unit fcp_pwm_unit_sva fcp_pwm_unit_sva_inst (.core_clk, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .pad_select, .led_port_bit_a,
    .led_port_bit_b, .led_port_bit_c, .led_port_bit_d, .led_port_oe);

// ===== verification/fcp_led_load.sv
// Purpose: LED loads on the four port pads, counting high cycles and rising edges.
// Assumes: Pads released by the unit are pulled up.
// Notes:   Counts restart on clr.
`timescale 1ns/10ps
// ==========
// Load model
module fcp_led_load (
    input  wire logic       core_clk,
    input  wire logic       clr,
    input  wire logic [3:0] drive,
    input  wire logic [3:0] oe,
    output logic      [7:0] hi [4],
    output logic      [7:0] rs [4]
);
    logic [3:0] lvl;
    logic [3:0] prev_reg;
    // A released pad floats up, so another function's pad reads steady high.
    assign lvl = (oe & drive) | ~oe;
    // Counting per pad keeps the check independent of where a period starts.
    always @(posedge core_clk) begin
        prev_reg <= lvl;
        for (int c = 0; c < 4; c++) begin
            hi[c] <= clr ? 8'h00 : hi[c] + {7'h00, lvl[c]};
            rs[c] <= clr ? 8'h00 : rs[c] + {7'h00, lvl[c] & ~prev_reg[c]};
        end
    end
endmodule

// ===== verification/fcp_pwm_unit_bench.sv
// Purpose: Self-checking bench for the four-channel pulse unit.
// Assumes: Zero-wait APB slave, divider shortened to 1.
// Notes:   Random values from a fixed seed.
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
// ==========
// Bench
module fcp_pwm_unit_bench;
    localparam int WIN = 30;
    localparam int DIV = 1;
    logic        core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, clr = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q, d;
    logic [3:0]  pad_select = 4'h0, oe, en, sel, inv;
    logic        pready, pslverr, la, lb, lc, ld;
    logic [7:0]  hi [4], rs [4];
    int          n_errors = 0, checked = 0, seed = 13, cyc = 0;
    fcp_pwm_unit fcp_pwm_unit_inst (.core_clk, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .pslverr, .prdata, .pad_select, .led_port_bit_a(la),
        .led_port_bit_b(lb), .led_port_bit_c(lc), .led_port_bit_d(ld), .led_port_oe(oe));
    fcp_led_load fcp_led_load_inst (.core_clk, .clr, .drive({ld, lc, lb, la}), .oe, .hi, .rs);
    always #5 core_clk = ~core_clk;
    // A hung handshake must still reach the verdict.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    function logic [11:0] ra(input int c, input int o);
        return 12'(c * 16 + o);
    endfunction
    // A stopped channel shows its inversion bit; a running uninverted one is high one step in three.
    function logic [7:0] exp_hi(input logic e, input logic i, input logic p);
        return !p ? 8'(WIN) : !e ? (i ? 8'(WIN) : 8'h00) : 8'(i ? WIN - WIN / 3 : WIN / 3);
    endfunction
    function logic [7:0] exp_rs(input logic e, input logic s, input logic p);
        return (!p || !e) ? 8'h00 : 8'(WIN / (3 * (s ? DIV + 1 : 1)));
    endfunction
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge core_clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        if (n == 20) n_errors++;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 32'h0);
        `CHK(q, e)
    endtask
    task print_verdict;
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Register access first, then running waveforms in several setups.
    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 0;
        rd_chk(12'h040, 32'h0);
        apb(1, 12'h044, 32'(DIV));
        rd_chk(12'h044, 32'(DIV));
        for (int c = 0; c < 4; c++) begin
            d = $random(seed);
            apb(1, ra(c, 0), d);
            rd_chk(ra(c, 0), {22'h0, d[9:0]});
            apb(1, ra(c, 4), ~d);
            rd_chk(ra(c, 4), {22'h0, ~d[9:0]});
            apb(1, ra(c, 8), 32'h0);
            rd_chk(ra(c, 8), {22'h0, d[9:0]});
        end
        d = $random(seed);
        apb(1, 12'h040, d);
        rd_chk(12'h040, {20'h0, d[11:0]});
        apb(1, 12'h048, d);
        rd_chk(12'h048, 32'h0);
        rd_chk(12'h00C, 32'h0);
        $display("register test done");
        // Stop every channel so that the new start counts load before any case runs.
        apb(1, 12'h040, 32'h0);
        for (int c = 0; c < 4; c++) begin
            apb(1, ra(c, 0), 32'h3FD);
            apb(1, ra(c, 4), 32'h3FE);
        end
        for (int k = 0; k < 6; k++) begin
            d = (k == 0) ? 32'h0000F00F : $random(seed);
            {pad_select, inv, sel, en} <= d[15:0];
            apb(1, 12'h040, d);
            // A running count stays inside its reload range; a stopped one sits at start.
            for (int c = 0; c < 4; c++) begin
                apb(0, ra(c, 8), 32'h0);
                `CHK(en[c] ? (q >= 32'h3FD && q <= 32'h3FF) : (q == 32'h3FD), 1'b1)
            end
            repeat (12) @(posedge core_clk);
            clr <= 1;
            @(posedge core_clk);
            clr <= 0;
            // The extra edge lets the last of the window's counts settle before they are read.
            repeat (WIN + 1) @(posedge core_clk);
            for (int c = 0; c < 4; c++) begin
                `CHK(hi[c], exp_hi(en[c], inv[c], pad_select[c]))
                `CHK(rs[c], exp_rs(en[c], sel[c], pad_select[c]))
            end
            $display("waveform case %0d done", k);
        end
        print_verdict();
    end
endmodule
